// ===== pkg/lpm_consts.svh
// Constants for the low-power mode supervisor: offsets, fields, resets, timing
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

`define LPM_ADDR_W          4
`define LPM_DATA_W          8
`define LPM_GATE_W          8
`define LPM_LVL_W           3
`define LPM_CNT_W           12

`define LPM_OFS_MODECTL     4'h0
`define LPM_OFS_WAITGATE    4'h1
`define LPM_OFS_SUPPLYCTL   4'h2
`define LPM_OFS_STATUS      4'h3
`define LPM_OFS_BROWNOUT    4'h4

`define LPM_MC_LPRUN        0
`define LPM_MC_ACTHALT      1
`define LPM_MC_REFOFF       2
`define LPM_MC_FASTWAKE     3

`define LPM_SC_EN           0
`define LPM_SC_LVL_LO       1
`define LPM_SC_LVL_HI       3
`define LPM_SC_FALL         4
`define LPM_SC_RISE         5

`define LPM_WAITGATE_RST    8'hFF
`define LPM_BROWNOUT_LVL_DEF 3'h0
`define LPM_BROWNOUT_LVL_MAX 3'h4
`define LPM_DETECT_LVL_MAX   3'h6
`define LPM_DATA_ZERO       8'h00

`define LPM_CLK_MHZ         125
`define LPM_FAST_WAKE_NS    5000
`define LPM_VREF_SETTLE_NS  3000
// Longest time: round down
`define LPM_FAST_WAKE_CYC   12'((`LPM_FAST_WAKE_NS * `LPM_CLK_MHZ) / 1000)
// Least time: round up
`define LPM_VREF_SETTLE_CYC 12'((`LPM_VREF_SETTLE_NS * `LPM_CLK_MHZ + 999) / 1000)

`endif

// ===== pkg/lpm_pkg.sv
// Types for the low-power mode supervisor
`default_nettype none
package lpm_pkg;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_LPRUN,
    MODE_LPWAIT,
    MODE_ACTHALT,
    MODE_HALT,
    MODE_RESUME
  } lpm_mode_e;

  typedef enum logic [1:0] {
    SUP_HOLD,
    SUP_LOAD,
    SUP_RUN
  } lpm_sup_e;

endpackage : lpm_pkg
`default_nettype wire

// ===== hw/lpm_sync.sv
// Two-flop synchroniser for a group of pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module lpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule : lpm_sync
`default_nettype wire

// ===== hw/lpm_countdown.sv
// Loadable down-counter giving a one-cycle done pulse
`timescale 1ns/10ps
`default_nettype none
`include "lpm_consts.svh"
module lpm_countdown (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  load,
  input  wire logic [`LPM_CNT_W-1:0] loadValue,
  output logic                       done
);

  logic [`LPM_CNT_W-1:0] count;
  logic                  running;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        count   <= loadValue;
        running <= 1'b1;
      end else if (running) begin
        if (count <= `LPM_CNT_W'(1)) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - `LPM_CNT_W'(1);
        end
      end
    end
  end

endmodule : lpm_countdown
`default_nettype wire

// ===== hw/lpm_supervisor.sv
// Low-power mode sequencer, clock gating, regulator and supply supervisor
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "lpm_consts.svh"
module lpm_supervisor (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Register port
  input  wire logic [`LPM_ADDR_W-1:0] regAddr,
  input  wire logic [`LPM_DATA_W-1:0] regWrData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [`LPM_DATA_W-1:0] regRdData,
  // Core side, same clock
  input  wire logic                   wait_for_interrupt_instr,
  input  wire logic                   wait_for_event_instr,
  input  wire logic                   haltInstr,
  input  wire logic                   internalIrq,
  // Pins and analog comparators, asynchronous
  input  wire logic                   externalIrq,
  input  wire logic                   rtcIrq,
  input  wire logic                   peripheralEvent,
  input  wire logic                   haltWakeReq,
  input  wire logic                   supplyAbovePowerOn,
  input  wire logic                   supplyAboveBrownout,
  input  wire logic                   supplyAboveLevel,
  // Option byte loader
  output logic                        optionLoadStart,
  input  wire logic                   optionLoadDone,
  input  wire logic [`LPM_LVL_W-1:0]  optionBrownoutLevel,
  input  wire logic                   optionBrownoutOff,
  // Gating and power controls
  output logic                        systemResetHold,
  output logic                        cpuClockEnable,
  output logic      [`LPM_GATE_W-1:0] peripheralClockEnable,
  output logic                        rtcClockEnable,
  output logic                        flashEnable,
  output logic                        ramExecute,
  output logic                        lowSpeedClockSelect,
  output logic                        low_power_regulator_setting,
  output logic                        referenceEnable,
  output logic                        brownoutActive,
  output logic      [`LPM_LVL_W-1:0]  brownoutLevel,
  output logic                        supplyDetectEnable,
  output logic      [`LPM_LVL_W-1:0]  supplyDetectLevel,
  output logic                        supplyDetectIrq
);

  lpm_pkg::lpm_mode_e    mode;
  lpm_pkg::lpm_mode_e    next_mode;
  lpm_pkg::lpm_sup_e     supState;

  logic                  extIrqS;
  logic                  rtcIrqS;
  logic                  periphEvtS;
  logic                  haltWakeS;
  logic                  powerOnOkS;
  logic                  brownoutOkS;
  logic                  levelAboveS;
  logic                  levelAbovePrev;

  logic                  activeHaltSel;
  logic                  refOffInHalt;
  logic                  fastWake;
  logic [`LPM_GATE_W-1:0] waitGate;
  logic                  detectEn;
  logic [`LPM_LVL_W-1:0] detectLvl;
  logic                  fallIrqEn;
  logic                  riseIrqEn;
  logic                  brownoutOff;
  logic                  refWasOff;

  logic                  writeModeCtl;
  logic                  lpRunEnter;
  logic                  lpRunLeave;
  logic                  haltWake;
  logic                  resumeDone;
  logic                  inHalt;
  logic                  supplyFault;
  logic [`LPM_CNT_W-1:0] resumeCount;

  lpm_sync #(
    .WIDTH (7)
  ) u_pinSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .async   ({externalIrq, rtcIrq, peripheralEvent, haltWakeReq,
               supplyAbovePowerOn, supplyAboveBrownout, supplyAboveLevel}),
    .synced  ({extIrqS, rtcIrqS, periphEvtS, haltWakeS,
               powerOnOkS, brownoutOkS, levelAboveS})
  );

  // Register writes
  assign writeModeCtl = regWrite && (regAddr == `LPM_OFS_MODECTL);
  assign lpRunEnter   = writeModeCtl && regWrWata_lp(regWrData) && (mode == lpm_pkg::MODE_RUN);
  assign lpRunLeave   = writeModeCtl && !regWrWata_lp(regWrData) && (mode == lpm_pkg::MODE_LPRUN);

  function automatic logic regWrWata_lp(input logic [`LPM_DATA_W-1:0] d);
    regWrWata_lp = d[`LPM_MC_LPRUN];
  endfunction : regWrWata_lp

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      activeHaltSel <= 1'b0;
      refOffInHalt  <= 1'b0;
      fastWake      <= 1'b0;
    end else if (writeModeCtl) begin
      activeHaltSel <= regWrData[`LPM_MC_ACTHALT];
      refOffInHalt  <= regWrData[`LPM_MC_REFOFF];
      fastWake      <= regWrData[`LPM_MC_FASTWAKE];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      waitGate <= `LPM_WAITGATE_RST;
    end else if (regWrite && (regAddr == `LPM_OFS_WAITGATE)) begin
      waitGate <= regWrData[`LPM_GATE_W-1:0];
    end
  end

  // Level 7 is not a valid threshold; clamp to the top one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      detectEn  <= 1'b0;
      detectLvl <= '0;
      fallIrqEn <= 1'b0;
      riseIrqEn <= 1'b0;
    end else if (regWrite && (regAddr == `LPM_OFS_SUPPLYCTL)) begin
      detectEn  <= regWrData[`LPM_SC_EN];
      detectLvl <= (regWrData[`LPM_SC_LVL_HI:`LPM_SC_LVL_LO] > `LPM_DETECT_LVL_MAX) ?
                   `LPM_DETECT_LVL_MAX : regWrData[`LPM_SC_LVL_HI:`LPM_SC_LVL_LO];
      fallIrqEn <= regWrData[`LPM_SC_FALL];
      riseIrqEn <= regWrData[`LPM_SC_RISE];
    end
  end

  // Reads: data valid the cycle after the strobe only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdData <= `LPM_DATA_ZERO;
    end else if (regRead) begin
      case (regAddr)
        `LPM_OFS_MODECTL:   regRdData <= {4'h0, fastWake, refOffInHalt, activeHaltSel,
                                          mode == lpm_pkg::MODE_LPRUN || mode == lpm_pkg::MODE_LPWAIT};
        `LPM_OFS_WAITGATE:  regRdData <= waitGate;
        `LPM_OFS_SUPPLYCTL: regRdData <= {2'h0, riseIrqEn, fallIrqEn, detectLvl, detectEn};
        `LPM_OFS_STATUS:    regRdData <= {low_power_regulator_setting, referenceEnable,
                                          brownoutActive, levelAboveS, 1'b0, mode};
        `LPM_OFS_BROWNOUT:  regRdData <= {3'h0, brownoutOff, 1'b0, brownoutLevel};
        default:            regRdData <= `LPM_DATA_ZERO;
      endcase
    end else begin
      regRdData <= `LPM_DATA_ZERO;
    end
  end

  // Supervisor: power-on hold, option load, run
  assign inHalt      = (mode == lpm_pkg::MODE_HALT) || (mode == lpm_pkg::MODE_ACTHALT);
  assign supplyFault = !powerOnOkS || (brownoutActive && !brownoutOkS);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      supState        <= lpm_pkg::SUP_HOLD;
      optionLoadStart <= 1'b0;
      brownoutOff     <= 1'b0;
      brownoutLevel   <= `LPM_BROWNOUT_LVL_DEF;
    end else begin
      optionLoadStart <= 1'b0;
      case (supState)
        lpm_pkg::SUP_HOLD: begin
          if (powerOnOkS && brownoutOkS) begin
            supState        <= lpm_pkg::SUP_LOAD;
            optionLoadStart <= 1'b1;
          end
        end
        lpm_pkg::SUP_LOAD: begin
          if (!powerOnOkS || !brownoutOkS) begin
            supState <= lpm_pkg::SUP_HOLD;
          end else if (optionLoadDone) begin
            supState      <= lpm_pkg::SUP_RUN;
            brownoutOff   <= optionBrownoutOff;
            brownoutLevel <= (optionBrownoutLevel > `LPM_BROWNOUT_LVL_MAX) ?
                             `LPM_BROWNOUT_LVL_MAX : optionBrownoutLevel;
          end
        end
        lpm_pkg::SUP_RUN: begin
          if (supplyFault) begin
            supState <= lpm_pkg::SUP_HOLD;
          end
        end
        default: supState <= lpm_pkg::SUP_HOLD;
      endcase
    end
  end

  // Brownout watched until options say otherwise, and not while the reference is off in halt
  always_comb begin
    if (supState != lpm_pkg::SUP_RUN) begin
      brownoutActive = 1'b1;
    end else begin
      brownoutActive = !brownoutOff && referenceEnable;
    end
  end

  assign systemResetHold = (supState != lpm_pkg::SUP_RUN);

  // Wake sources sampled on the free-running clock, so gating never blinds them
  assign haltWake = (mode == lpm_pkg::MODE_HALT) ? (extIrqS || haltWakeS) :
                    (rtcIrqS || extIrqS);

  always_comb begin
    next_mode = mode;
    case (mode)
      lpm_pkg::MODE_RUN: begin
        if (lpRunEnter) begin
          next_mode = lpm_pkg::MODE_LPRUN;
        end else if (haltInstr) begin
          next_mode = activeHaltSel ? lpm_pkg::MODE_ACTHALT : lpm_pkg::MODE_HALT;
        end else if (wait_for_interrupt_instr || wait_for_event_instr) begin
          next_mode = lpm_pkg::MODE_WAIT;
        end
      end
      lpm_pkg::MODE_WAIT: begin
        if (internalIrq || extIrqS) begin
          next_mode = lpm_pkg::MODE_RUN;
        end
      end
      // Interrupts are deliberately not looked at here
      lpm_pkg::MODE_LPRUN: begin
        if (lpRunLeave) begin
          next_mode = lpm_pkg::MODE_RUN;
        end else if (wait_for_event_instr) begin
          next_mode = lpm_pkg::MODE_LPWAIT;
        end
      end
      lpm_pkg::MODE_LPWAIT: begin
        if (periphEvtS) begin
          next_mode = lpm_pkg::MODE_LPRUN;
        end
      end
      lpm_pkg::MODE_ACTHALT,
      lpm_pkg::MODE_HALT: begin
        if (haltWake) begin
          next_mode = lpm_pkg::MODE_RESUME;
        end
      end
      lpm_pkg::MODE_RESUME: begin
        if (resumeDone) begin
          next_mode = lpm_pkg::MODE_RUN;
        end
      end
      default: next_mode = lpm_pkg::MODE_RUN;
    endcase
  end

  // Reset of the system returns every mode to run
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode <= lpm_pkg::MODE_RUN;
    end else if (systemResetHold) begin
      mode <= lpm_pkg::MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Remember whether the reference was off, to know the resume wait
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      refWasOff <= 1'b0;
    end else if (inHalt) begin
      refWasOff <= refOffInHalt;
    end
  end

  // Settling adds to the base wake, so fast wake is never the slower path
  assign resumeCount = (refWasOff && !fastWake) ?
                       `LPM_FAST_WAKE_CYC + `LPM_VREF_SETTLE_CYC : `LPM_FAST_WAKE_CYC;

  lpm_countdown u_resumeTimer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .load      (inHalt && haltWake && !systemResetHold),
    .loadValue (resumeCount),
    .done      (resumeDone)
  );

  // Gating outputs registered from the next mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cpuClockEnable        <= 1'b1;
      peripheralClockEnable <= '1;
      rtcClockEnable        <= 1'b1;
      flashEnable           <= 1'b1;
      ramExecute            <= 1'b0;
      lowSpeedClockSelect   <= 1'b0;
    end else begin
      cpuClockEnable        <= 1'b0;
      peripheralClockEnable <= '0;
      rtcClockEnable        <= 1'b1;
      flashEnable           <= 1'b1;
      ramExecute            <= 1'b0;
      lowSpeedClockSelect   <= 1'b0;
      case (systemResetHold ? lpm_pkg::MODE_RUN : next_mode)
        lpm_pkg::MODE_RUN: begin
          cpuClockEnable        <= 1'b1;
          peripheralClockEnable <= '1;
        end
        lpm_pkg::MODE_WAIT: begin
          peripheralClockEnable <= waitGate;
        end
        lpm_pkg::MODE_LPRUN,
        lpm_pkg::MODE_LPWAIT: begin
          cpuClockEnable        <= (next_mode == lpm_pkg::MODE_LPRUN);
          peripheralClockEnable <= waitGate;
          flashEnable           <= 1'b0;
          ramExecute            <= 1'b1;
          lowSpeedClockSelect   <= 1'b1;
        end
        lpm_pkg::MODE_ACTHALT: begin
          flashEnable <= 1'b0;
        end
        lpm_pkg::MODE_HALT: begin
          rtcClockEnable <= 1'b0;
          flashEnable    <= 1'b0;
        end
        lpm_pkg::MODE_RESUME: begin
          rtcClockEnable <= 1'b1;
        end
        default: begin
          cpuClockEnable <= 1'b1;
        end
      endcase
    end
  end

  // Regulator and reference follow the mode without software help
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      low_power_regulator_setting <= 1'b0;
      referenceEnable             <= 1'b1;
    end else if (systemResetHold) begin
      low_power_regulator_setting <= 1'b0;
      referenceEnable             <= 1'b1;
    end else begin
      case (next_mode)
        lpm_pkg::MODE_LPRUN,
        lpm_pkg::MODE_LPWAIT: begin
          low_power_regulator_setting <= 1'b1;
          referenceEnable             <= 1'b1;
        end
        lpm_pkg::MODE_ACTHALT,
        lpm_pkg::MODE_HALT: begin
          low_power_regulator_setting <= 1'b1;
          referenceEnable             <= !refOffInHalt;
        end
        default: begin
          low_power_regulator_setting <= 1'b0;
          referenceEnable             <= 1'b1;
        end
      endcase
    end
  end

  // Supply-level detector: edges of the comparator level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      levelAbovePrev  <= 1'b0;
      supplyDetectIrq <= 1'b0;
    end else begin
      levelAbovePrev  <= levelAboveS;
      supplyDetectIrq <= detectEn && ((fallIrqEn && levelAbovePrev && !levelAboveS) ||
                                      (riseIrqEn && !levelAbovePrev && levelAboveS));
    end
  end

  assign supplyDetectEnable = detectEn;
  assign supplyDetectLevel  = detectLvl;

endmodule : lpm_supervisor
`default_nettype wire

// ===== testbench/lpm_supervisor_assertions.sv
// Port-level assertions for the low-power mode supervisor
`timescale 1ns/10ps
`default_nettype none
`include "lpm_consts.svh"
module lpm_supervisor_assertions (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   regWrite,
  input wire logic                   wait_for_interrupt_instr,
  input wire logic                   wait_for_event_instr,
  input wire logic                   haltInstr,
  input wire logic                   externalIrq,
  input wire logic                   peripheralEvent,
  input wire logic                   supplyAbovePowerOn,
  input wire logic                   systemResetHold,
  input wire logic                   cpuClockEnable,
  input wire logic [`LPM_GATE_W-1:0] peripheralClockEnable,
  input wire logic                   flashEnable,
  input wire logic                   ramExecute,
  input wire logic                   lowSpeedClockSelect,
  input wire logic                   low_power_regulator_setting,
  input wire logic                   supplyDetectEnable,
  input wire logic                   supplyDetectIrq,
  input wire logic                   optionLoadStart,
  input wire logic                   brownoutActive
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Plain run: core clocked from flash, supervisor released
  logic run;
  assign run = cpuClockEnable && flashEnable && !ramExecute && !systemResetHold;

  wait_gate_a: assert property (
    run && wait_for_interrupt_instr && !haltInstr && !regWrite |=> !cpuClockEnable && flashEnable
    && !low_power_regulator_setting) else $error("wait entry gating wrong");
  halt_gate_a: assert property (
    run && haltInstr && !regWrite |=> !cpuClockEnable && !flashEnable && low_power_regulator_setting
    && peripheralClockEnable == '0) else $error("halt entry gating wrong");
  lprun_cfg_a: assert property (
    ramExecute |-> lowSpeedClockSelect && !flashEnable && low_power_regulator_setting)
    else $error("low-power run setup wrong");
  lprun_hold_a: assert property (
    ramExecute && cpuClockEnable && !regWrite && !wait_for_event_instr |=>
    (ramExecute && cpuClockEnable) || systemResetHold) else $error("low-power run left unasked");
  lpwait_in_a: assert property (
    ramExecute && cpuClockEnable && wait_for_event_instr && !regWrite |=>
    (ramExecute && !cpuClockEnable) || systemResetHold) else $error("low-power wait not entered");
  lpwait_wake_a: assert property (
    (ramExecute && !cpuClockEnable && peripheralEvent) [*3] |-> ##[0:3] (cpuClockEnable && ramExecute))
    else $error("event did not end low-power wait");
  halt_wake_a: assert property (
    (!cpuClockEnable && !flashEnable && !ramExecute && low_power_regulator_setting && externalIrq) [*3]
    |-> ##[0:3] !low_power_regulator_setting) else $error("halt ignored external wake");
  resume_len_a: assert property (
    $fell(low_power_regulator_setting) && !cpuClockEnable && !ramExecute |->
    (!cpuClockEnable throughout ##300 1) ##[1:800] cpuClockEnable) else $error("resume length wrong");
  hold_low_a: assert property (
    (!supplyAbovePowerOn) [*3] |-> ##[0:3] systemResetHold) else $error("reset not held on low supply");
  boot_brownout_a: assert property (
    optionLoadStart |-> brownoutActive) else $error("option load with brownout off");
  irq_en_a: assert property (
    supplyDetectIrq |-> supplyDetectEnable) else $error("detector irq while disabled");

  cover property (run && haltInstr);
  cover property (ramExecute && !cpuClockEnable);
  cover property (supplyDetectIrq);
endmodule : lpm_supervisor_assertions

bind lpm_supervisor lpm_supervisor_assertions u_chk (.clk_sys, .reset, .regWrite, .wait_for_interrupt_instr,
  .wait_for_event_instr, .haltInstr, .externalIrq, .peripheralEvent, .supplyAbovePowerOn, .systemResetHold,
  .cpuClockEnable, .peripheralClockEnable, .flashEnable, .ramExecute, .lowSpeedClockSelect,
  .low_power_regulator_setting, .supplyDetectEnable, .supplyDetectIrq, .optionLoadStart, .brownoutActive);
`default_nettype wire

// ===== testbench/lpm_opt_loader_model.sv
// Option byte loader model answering the supervisor's load request
`timescale 1ns/10ps
`default_nettype none
`include "lpm_consts.svh"
module lpm_opt_loader_model #(
  parameter int                    DELAY = 5,
  parameter logic [`LPM_LVL_W-1:0] LEVEL = 3'h5
) (
  input  wire logic                 clk_sys,
  input  wire logic                 optionLoadStart,
  output logic                      optionLoadDone,
  output logic [`LPM_LVL_W-1:0]     optionBrownoutLevel,
  output logic                      optionBrownoutOff
);
  int   count = 0;
  logic done = 1'b0;
  always @(posedge clk_sys) begin
    done <= count == 1;
    if (optionLoadStart)
      count <= DELAY;
    else if (count > 0)
      count <= count - 1;
  end
  // Option lines only valid beside done, so show junk otherwise
  assign optionLoadDone = done;
  assign optionBrownoutLevel = done ? LEVEL : ~LEVEL;
  assign optionBrownoutOff = ~done;
endmodule : lpm_opt_loader_model
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the low-power mode supervisor
`timescale 1ns/10ps
`default_nettype none
`include "lpm_consts.svh"
module tb;
  logic       clk_sys = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, v;
  logic       wait_for_interrupt_instr = 1'b0, wait_for_event_instr = 1'b0, haltInstr = 1'b0, internalIrq = 1'b0;
  logic       externalIrq = 1'b0, rtcIrq = 1'b0, peripheralEvent = 1'b0, haltWakeReq = 1'b0;
  logic       supplyAbovePowerOn = 1'b1, supplyAboveBrownout = 1'b1, supplyAboveLevel = 1'b1;
  wire  [7:0] regRdData, peripheralClockEnable;
  wire  [2:0] brownoutLevel, supplyDetectLevel, optionBrownoutLevel;
  wire        optionLoadStart, optionLoadDone, optionBrownoutOff, systemResetHold, cpuClockEnable, rtcClockEnable;
  wire        flashEnable, ramExecute, lowSpeedClockSelect, low_power_regulator_setting, referenceEnable;
  wire        brownoutActive, supplyDetectEnable, supplyDetectIrq;
  int         failures = 0, comparisons = 0, n, m;
  logic [7:0] hc [3] = '{8'h00, 8'h0C, 8'h06};
  logic [7:0] sc [4] = '{8'h3F, 8'h15, 8'h2B, 8'h30};

  lpm_supervisor uut (.*);
  lpm_opt_loader_model model (.*);

  always #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
  task automatic pulse(input logic [3:0] k);
    @(posedge clk_sys);
    {internalIrq, haltInstr, wait_for_event_instr, wait_for_interrupt_instr} <= k;
    @(posedge clk_sys);
    {internalIrq, haltInstr, wait_for_event_instr, wait_for_interrupt_instr} <= 4'h0;
    #1;
  endtask : pulse
  task automatic mode(input logic [2:0] md);
    rd(`LPM_OFS_STATUS, v);
    chk(v[2:0], md);
  endtask : mode
  task automatic until_cpu;
    for (n = 0; n < 1100 && cpuClockEnable !== 1'b1; n++) tick(1);
  endtask : until_cpu
  task automatic edge_irq(input logic lvl, input logic e);
    @(posedge clk_sys);
    supplyAboveLevel <= lvl;
    m = 0;
    repeat (8) begin
      tick(1);
      if (supplyDetectIrq === 1'b1) m++;
    end
    chk(m, e);
  endtask : edge_irq
  task automatic finish_test;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    tick(1);
    chk(brownoutActive, 1'b1);
    for (n = 0; n < 50 && systemResetHold !== 1'b0; n++) tick(1);
    chk(systemResetHold, 1'b0);
    chk(brownoutLevel, `LPM_BROWNOUT_LVL_MAX);
    rd(`LPM_OFS_WAITGATE, v);
    chk(v, `LPM_WAITGATE_RST);
    wr(4'hF, 8'h55);
    rd(4'hF, v);
    chk(v, `LPM_DATA_ZERO);
    wr(`LPM_OFS_WAITGATE, 8'h3C);
    pulse(4'h1);
    chk({cpuClockEnable, peripheralClockEnable, flashEnable, low_power_regulator_setting}, 11'h0F2);
    mode(3'h1);
    pulse(4'h8);
    chk(cpuClockEnable, 1'b1);
    pulse(4'h2);
    mode(3'h1);
    @(posedge clk_sys);
    externalIrq <= 1'b1;
    until_cpu();
    chk(cpuClockEnable, 1'b1);
    // Low-power run must shrug off every interrupt
    wr(`LPM_OFS_MODECTL, 8'h01);
    chk({ramExecute, lowSpeedClockSelect, flashEnable, low_power_regulator_setting, peripheralClockEnable},
        12'hD3C);
    pulse(4'h9);
    tick(6);
    mode(3'h2);
    pulse(4'h2);
    chk({ramExecute, cpuClockEnable}, 2'b10);
    tick(4);
    mode(3'h3);
    @(posedge clk_sys);
    {externalIrq, peripheralEvent} <= 2'b01;
    until_cpu();
    mode(3'h2);
    @(posedge clk_sys);
    peripheralEvent <= 1'b0;
    wr(`LPM_OFS_MODECTL, 8'h00);
    chk({ramExecute, flashEnable, low_power_regulator_setting}, 3'b010);
    for (int i = 0; i < 3; i++) begin
      wr(`LPM_OFS_MODECTL, hc[i]);
      pulse(4'h4);
      chk({cpuClockEnable, flashEnable, low_power_regulator_setting, peripheralClockEnable}, 11'h100);
      chk(rtcClockEnable, hc[i][1]);
      chk({referenceEnable, brownoutActive}, {2{!hc[i][2]}});
      @(posedge clk_sys);
      {rtcIrq, externalIrq, haltWakeReq} <= 3'(1 << i);
      for (n = 0; n < 10 && low_power_regulator_setting !== 1'b0; n++) tick(1);
      until_cpu();
      m = (hc[i][3] || !hc[i][2]) ? `LPM_FAST_WAKE_CYC : `LPM_FAST_WAKE_CYC + `LPM_VREF_SETTLE_CYC;
      chk(n >= m && n <= m + 4, 1'b1);
      chk(peripheralClockEnable, 8'hFF);
      @(posedge clk_sys);
      {rtcIrq, externalIrq, haltWakeReq} <= 3'h0;
    end
    for (int i = 0; i < 4; i++) begin
      wr(`LPM_OFS_SUPPLYCTL, sc[i]);
      chk({supplyDetectEnable, supplyDetectLevel}, {sc[i][0], sc[i][3:1] > 6 ? 3'h6 : sc[i][3:1]});
      edge_irq(1'b0, sc[i][0] & sc[i][4]);
      edge_irq(1'b1, sc[i][0] & sc[i][5]);
    end
    @(posedge clk_sys);
    supplyAbovePowerOn <= 1'b0;
    tick(6);
    chk(systemResetHold, 1'b1);
    @(posedge clk_sys);
    supplyAbovePowerOn <= 1'b1;
    for (n = 0; n < 50 && systemResetHold !== 1'b0; n++) tick(1);
    chk(systemResetHold, 1'b0);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
